// file: core/opsc_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module opsc_debounce import opsc_pkg::*; #(
  parameter int unsigned STABLE_CYC = DEB_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic rawIn, // Raw contact level
  output logic cleanOut // Debounced level
);
  logic [31:0] cnt_r;

  // Follow the input only after it stays put for the whole window
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 32'h0;
      cleanOut <= 1'b0;
    end else if (rawIn == cleanOut) begin
      cnt_r <= 32'h0;
    end else if (cnt_r >= STABLE_CYC - 1) begin
      cnt_r <= 32'h0;
      cleanOut <= rawIn;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule
`default_nettype wire

// file: core/opsc_panel.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module opsc_panel import opsc_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC, // Long press time
  parameter int unsigned IDLE_CYCLES = IDLE_CYC, // Warning idle time
  parameter int unsigned SAVE_CYCLES = SAVE_CYC, // Store delay
  parameter int unsigned DEB_CYCLES = DEB_CYC // Debounce window
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic modeKey, // Mode key contact
  input wire logic setKey, // Set key contact
  input wire logic runKey, // Run key contact
  input wire logic stopKey, // Stop key contact
  input wire logic dialUp, // Dial click, increase
  input wire logic dialDown, // Dial click, decrease
  input wire logic editSetFreq, // Set frequency being edited
  input wire logic keypadUnitPresent, // Plug-in keypad detected
  output logic runStart, // Start pulse
  output logic runReverse, // Direction for start
  output logic stopCmd, // Stop pulse
  output logic [19:0] runFreq, // Running frequency, 0.01 Hz
  output logic otherInc, // Dial up for other parameter
  output logic otherDec, // Dial down for other parameter
  output logic nvWrite, // Store pulse to memory
  output logic [19:0] nvData, // Frequency to store
  output logic lockInd, // Lock indication shown
  output logic lockWarn, // Locked warning shown
  output logic buzzerBeep, // Beep pulse
  output logic [5:0] lcdContrast, // Contrast level
  output logic [2:0] keypadLanguage, // Language code
  output logic contrastListed // Contrast in simple list
);
  logic [KEY_N-1:0] rawKeys;
  logic [KEY_N-1:0] cleanKeys;
  logic [KEY_N-1:0] prevKeys_r;
  logic [KEY_N-1:0] press;
  logic runDir_r;
  logic [2:0] lang_r;
  logic [3:0] lockSel_r;
  logic [2:0] stepCode_r;
  logic buzz_r;
  logic [5:0] contrast_r;
  logic [15:0] extSel_r;
  logic [1:0] wprot_r;
  logic mspeed_r;
  logic [19:0] setFreq_r;
  logic [19:0] setFreq_nxt;
  logic [19:0] editFreq_r;
  logic [19:0] editFreq_nxt;
  logic locked_r;
  logic holdDone_r;
  logic [31:0] holdCnt_r;
  logic [31:0] idleCnt_r;
  logic [31:0] saveCnt_r;
  logic savePend_r;
  logic apbWr;
  logic cfgWr;
  logic freqWr;
  logic potMode;
  logic lockAvail;
  logic dialAct;
  logic anyAct;
  logic [19:0] stepNow;

  // Effective dial step from code and display resolution
  function automatic logic [19:0] effStep(input logic [2:0] code, input logic [19:0] f,
                                          input logic speedSel);
    logic [19:0] s;
    s = STEP_0P01;
    case (code)
      3'h2: s = STEP_0P10;
      3'h3: s = STEP_1P00;
      3'h4: s = STEP_10P0;
      default: s = STEP_0P01;
    endcase
    if (f >= FREQ_HIRES && s < STEP_0P10) begin
      s = STEP_0P10;
    end
    if (speedSel && f >= SPEED_HIRES && s < STEP_1P00) begin
      s = STEP_1P00;
    end
    return s;
  endfunction

  // One click moves one step, clamped to range
  function automatic logic [19:0] stepFreq(input logic [19:0] f, input logic up,
                                           input logic [19:0] s);
    logic [20:0] sum;
    sum = {1'b0, f} + {1'b0, s};
    if (up) begin
      return (sum > {1'b0, FREQ_MAX}) ? FREQ_MAX : sum[19:0];
    end
    return (f > s) ? f - s : FREQ_RST;
  endfunction

  assign rawKeys = {dialDown, dialUp, stopKey, runKey, setKey, modeKey};

  // Contact bounce filtering on every key and dial input
  generate
    for (genvar i = 0; i < KEY_N; i++) begin : g_deb
      opsc_debounce #(.STABLE_CYC(DEB_CYCLES)) u_deb (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .rawIn(rawKeys[i]),
        .cleanOut(cleanKeys[i])
      );
    end
  endgenerate

  // Rising edge of each debounced input is one event
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prevKeys_r <= '0;
    end else begin
      prevKeys_r <= cleanKeys;
    end
  end
  assign press = cleanKeys & ~prevKeys_r;

  // Odd setting selects potentiometer style
  assign potMode = lockSel_r[0];
  assign lockAvail = lockSel_r[3];
  assign dialAct = press[K_UP] | press[K_DOWN];
  assign anyAct = dialAct | press[K_SET] | press[K_RUN] | press[K_MODE];
  assign stepNow = effStep(stepCode_r, editFreq_r, mspeed_r);

  // Bus decode; one wait state gives registered read data
  assign apbWr = psel & penable & pwrite & pready & ~pslverr;
  assign cfgWr = apbWr && paddr == CFG_OFS;
  assign freqWr = apbWr && paddr == FREQ_OFS;

  // APB answer, ready one cycle into the access phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      case (paddr)
        CFG_OFS: prdata <= {10'h0, contrast_r, 3'h0, buzz_r, 1'b0, stepCode_r,
                            lockSel_r, lang_r, runDir_r};
        MODE_OFS: prdata <= {11'h0, mspeed_r, 2'h0, wprot_r, extSel_r};
        FREQ_OFS: prdata <= {12'h0, setFreq_r};
        STAT_OFS: prdata <= {27'h0, contrastListed, keypadUnitPresent, savePend_r,
                             lockWarn, locked_r};
        STORE_OFS: prdata <= {12'h0, nvData};
        default: pslverr <= 1'b1;
      endcase
      if (pwrite && paddr == STAT_OFS) begin
        pslverr <= 1'b1; // Status is read only
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Panel settings; all but contrast gated by the extended display selection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      runDir_r <= RUNDIR_RST;
      lang_r <= LANG_RST;
      lockSel_r <= LOCKSEL_RST;
      stepCode_r <= STEP_RST;
      buzz_r <= BUZZ_RST;
      contrast_r <= CONTRAST_RST;
    end else if (cfgWr) begin
      contrast_r <= pwdata[CONTRAST_POS +: 6];
      if (extSel_r == 16'h0) begin
        runDir_r <= pwdata[RUNDIR_POS];
        lang_r <= pwdata[LANG_POS +: 3];
        buzz_r <= pwdata[BUZZ_POS];
        // Out of range values leave the field unchanged
        case (pwdata[LOCKSEL_POS +: 4])
          LOCK_SET_NOLOCK, LOCK_POT_NOLOCK, LOCK_SET_LOCK, LOCK_POT_LOCK:
            lockSel_r <= pwdata[LOCKSEL_POS +: 4];
          default: lockSel_r <= lockSel_r;
        endcase
        if (pwdata[STEP_POS +: 3] <= STEP_CODE_MAX) begin
          stepCode_r <= pwdata[STEP_POS +: 3];
        end
      end
    end
  end

  // Mode register, always writable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extSel_r <= EXTSEL_RST;
      wprot_r <= WPROT_RST;
      mspeed_r <= MSPEED_RST;
    end else if (apbWr && paddr == MODE_OFS) begin
      extSel_r <= pwdata[EXTSEL_POS +: 16];
      wprot_r <= pwdata[WPROT_POS +: 2];
      mspeed_r <= pwdata[MSPEED_POS];
    end
  end

  // Mode key hold timer; fires once per continuous press
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      holdCnt_r <= 32'h0;
      holdDone_r <= 1'b0;
      locked_r <= 1'b0;
    end else if (!cleanKeys[K_MODE]) begin
      holdCnt_r <= 32'h0;
      holdDone_r <= 1'b0;
      if (!lockAvail) begin
        locked_r <= 1'b0; // Lock disappears with the selection
      end
    end else if (!holdDone_r) begin
      if (holdCnt_r >= HOLD_CYCLES - 1) begin
        holdDone_r <= 1'b1;
        if (lockAvail) begin
          locked_r <= ~locked_r;
        end
      end else begin
        holdCnt_r <= holdCnt_r + 32'h1;
      end
    end
  end

  // Locked warning; cleared after idle time without activity
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt_r <= 32'h0;
      lockWarn <= 1'b0;
    end else if (!locked_r) begin
      idleCnt_r <= 32'h0;
      lockWarn <= 1'b0;
    end else if (anyAct && !holdDone_r) begin
      idleCnt_r <= 32'h0;
      lockWarn <= 1'b1;
    end else if (lockWarn) begin
      if (idleCnt_r >= IDLE_CYCLES - 1) begin
        lockWarn <= 1'b0;
        idleCnt_r <= 32'h0;
      end else begin
        idleCnt_r <= idleCnt_r + 32'h1;
      end
    end
  end

  // Dial editing of the frequency
  always_comb begin
    setFreq_nxt = setFreq_r;
    editFreq_nxt = editFreq_r;
    if (freqWr) begin
      setFreq_nxt = (pwdata[19:0] > FREQ_MAX) ? FREQ_MAX : pwdata[19:0];
      editFreq_nxt = setFreq_nxt;
    end
    if (!locked_r && editSetFreq && dialAct) begin
      editFreq_nxt = stepFreq(editFreq_r, press[K_UP], stepNow);
      if (potMode) begin
        setFreq_nxt = editFreq_nxt;
      end
    end
    if (!locked_r && !potMode && press[K_SET] && editSetFreq) begin
      setFreq_nxt = editFreq_r; // Set style confirms here
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      setFreq_r <= FREQ_RST;
      editFreq_r <= FREQ_RST;
    end else begin
      setFreq_r <= setFreq_nxt;
      editFreq_r <= editFreq_nxt;
    end
  end

  // Store timer restarts on each change, so only the settled value is written
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      saveCnt_r <= 32'h0;
      savePend_r <= 1'b0;
      nvWrite <= 1'b0;
      nvData <= FREQ_RST;
    end else begin
      nvWrite <= 1'b0;
      if (setFreq_nxt != setFreq_r) begin
        saveCnt_r <= 32'h0;
        savePend_r <= 1'b1;
      end else if (savePend_r) begin
        if (saveCnt_r >= SAVE_CYCLES - 1) begin
          savePend_r <= 1'b0;
          nvWrite <= 1'b1;
          nvData <= setFreq_r;
        end else begin
          saveCnt_r <= saveCnt_r + 32'h1;
        end
      end
    end
  end

  // Key actions toward the drive core
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      runStart <= 1'b0;
      runReverse <= RUNDIR_RST;
      stopCmd <= 1'b0;
      otherInc <= 1'b0;
      otherDec <= 1'b0;
      runFreq <= FREQ_RST;
    end else begin
      runStart <= press[K_RUN] & ~locked_r;
      runReverse <= runDir_r;
      stopCmd <= press[K_STOP];
      otherInc <= press[K_UP] & ~editSetFreq & ~locked_r;
      otherDec <= press[K_DOWN] & ~editSetFreq & ~locked_r;
      runFreq <= setFreq_r;
    end
  end

  // Keypad unit outputs; beep only on an accepted key press
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      buzzerBeep <= 1'b0;
      lcdContrast <= CONTRAST_RST;
      keypadLanguage <= LANG_RST;
      contrastListed <= 1'b0;
      lockInd <= 1'b0;
    end else begin
      buzzerBeep <= buzz_r & (press[K_STOP] | (anyAct & ~dialAct & ~locked_r));
      lcdContrast <= contrast_r;
      keypadLanguage <= lang_r;
      contrastListed <= keypadUnitPresent;
      lockInd <= locked_r;
    end
  end
endmodule
`default_nettype wire

// file: dv/opsc_operator.sv
`timescale 1ns/1ps
`default_nettype none
module opsc_operator import opsc_pkg::*; #(
  parameter int unsigned DEB = 3
) (
  input wire logic sys_clk, // System clock
  output logic modeKey, // Mode contact
  output logic setKey, // Set contact
  output logic runKey, // Run contact
  output logic stopKey, // Stop contact
  output logic dialUp, // Dial up line
  output logic dialDown // Dial down line
);
  logic [KEY_N-1:0] keys_r;
  // Contacts idle open
  initial keys_r = '0;
  assign {dialDown, dialUp, stopKey, runKey, setKey, modeKey} = keys_r;
  // Hold past the debounce window, then a quiet gap so presses never merge
  task automatic tap(input int k, input int hold);
    @(posedge sys_clk);
    keys_r[k] <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    keys_r[k] <= 1'b0;
    repeat (DEB + 6) @(posedge sys_clk);
  endtask
  // Unlock first, only then a key may restart the drive
  task automatic resume(input int hold);
    tap(K_MODE, hold);
    tap(K_RUN, DEB + 3);
  endtask
endmodule
`default_nettype wire

// file: dv/opsc_panel_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module opsc_panel_monitor import opsc_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic modeKey, // Mode contact
  input wire logic editSetFreq, // Set frequency edit
  input wire logic keypadUnitPresent, // Keypad present
  input wire logic runStart, // Start pulse
  input wire logic stopCmd, // Stop pulse
  input wire logic otherInc, // Other up
  input wire logic otherDec, // Other down
  input wire logic nvWrite, // Store pulse
  input wire logic lockInd, // Locked
  input wire logic lockWarn, // Locked warning
  input wire logic [5:0] lcdContrast, // Contrast
  input wire logic [2:0] keypadLanguage, // Language
  input wire logic contrastListed // Listed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] modeCnt_r;
  // Raw contact time; debounce only adds to the wait, so a bound holds
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) modeCnt_r <= '0;
    else modeCnt_r <= modeKey ? modeCnt_r + 32'h1 : '0;
  end
  AST_LOCK_HOLD: assert property ($changed(lockInd) |-> modeCnt_r >= HOLD_CYCLES)
    else $error("lock toggled without long mode press");
  AST_WARN_LOCKED: assert property ($rose(lockWarn) |-> lockInd)
    else $error("warning while unlocked");
  AST_RUN_BLOCKED: assert property (runStart |-> !lockInd)
    else $error("start while locked");
  AST_STOP_PULSE: assert property (stopCmd |=> !stopCmd)
    else $error("stop not a pulse");
  AST_RESET_VAL: assert property ($rose(reset_n) |->
    lcdContrast == CONTRAST_RST && keypadLanguage == LANG_RST)
    else $error("bad reset levels");
  AST_LIST: assert property ($changed(keypadUnitPresent) |=>
    contrastListed == $past(keypadUnitPresent))
    else $error("listing lags keypad");
  AST_OTHER_EDIT: assert property ((otherInc || otherDec) |->
    !(otherInc && otherDec) && !editSetFreq && !lockInd)
    else $error("bad other step");
  AST_APB_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready ##1 !pready)
    else $error("ready timing");
  // Main scenarios reached
  cover property ($rose(lockInd));
  cover property (nvWrite);
  cover property (stopCmd && lockInd);
  cover property (otherInc);
endmodule
bind opsc_panel opsc_panel_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
  .modeKey(modeKey), .editSetFreq(editSetFreq), .keypadUnitPresent(keypadUnitPresent),
  .runStart(runStart), .stopCmd(stopCmd), .otherInc(otherInc), .otherDec(otherDec),
  .nvWrite(nvWrite), .lockInd(lockInd), .lockWarn(lockWarn), .lcdContrast(lcdContrast),
  .keypadLanguage(keypadLanguage), .contrastListed(contrastListed));
`default_nettype wire

// file: dv/opsc_panel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module opsc_panel_tb import opsc_pkg::*; ;
  localparam int HOLD = 20;
  localparam int IDLE = 20;
  localparam int SAVE = 50;
  localparam int DEB = 3;
  localparam int LP = HOLD + DEB + 10;
  logic sys_clk, reset_n, psel, penable, pwrite, editSetFreq, keypadUnitPresent, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, runStart, runReverse, stopCmd, otherInc, otherDec, nvWrite;
  logic lockInd, lockWarn, buzzerBeep, contrastListed;
  logic [19:0] runFreq, nvData, f;
  logic [5:0] lcdContrast;
  logic [2:0] keypadLanguage;
  wire logic modeKey, setKey, runKey, stopKey, dialUp, dialDown;
  int miscompares, samples_checked, cyc, nInc, nDec, nRun, nStop, nBeep, nNv, n0;
  logic [19:0] stepv [5] = '{STEP_0P01, STEP_0P01, STEP_0P10, STEP_1P00, STEP_10P0};

  opsc_panel #(.HOLD_CYCLES(HOLD), .IDLE_CYCLES(IDLE), .SAVE_CYCLES(SAVE),
    .DEB_CYCLES(DEB)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modeKey(modeKey), .setKey(setKey), .runKey(runKey), .stopKey(stopKey),
    .dialUp(dialUp), .dialDown(dialDown), .editSetFreq(editSetFreq),
    .keypadUnitPresent(keypadUnitPresent), .runStart(runStart), .runReverse(runReverse),
    .stopCmd(stopCmd), .runFreq(runFreq), .otherInc(otherInc), .otherDec(otherDec),
    .nvWrite(nvWrite), .nvData(nvData), .lockInd(lockInd), .lockWarn(lockWarn),
    .buzzerBeep(buzzerBeep), .lcdContrast(lcdContrast), .keypadLanguage(keypadLanguage),
    .contrastListed(contrastListed));
  opsc_operator #(.DEB(DEB)) op (.sys_clk(sys_clk), .modeKey(modeKey), .setKey(setKey),
    .runKey(runKey), .stopKey(stopKey), .dialUp(dialUp), .dialDown(dialDown));

  // Clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Pulse tally and hang guard
  always @(posedge sys_clk) begin
    nInc += int'(otherInc === 1'b1);
    nDec += int'(otherDec === 1'b1);
    nRun += int'(runStart === 1'b1);
    nStop += int'(stopCmd === 1'b1);
    nBeep += int'(buzzerBeep === 1'b1);
    nNv += int'(nvWrite === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One transfer; request held until ready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the global cycle ceiling ends a wait
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cfg(logic d, logic [2:0] l, logic [3:0] s,
    logic [2:0] st, logic b, logic [5:0] c);
    return {10'h0, c, 3'h0, b, 1'b0, st, s, l, d};
  endfunction

  task automatic t_reset;
    apb(CFG_OFS, 0, 0);
    cmp(q, cfg(RUNDIR_RST, LANG_RST, LOCKSEL_RST, STEP_RST, BUZZ_RST,
      CONTRAST_RST), "cfg");
    apb(MODE_OFS, 0, 0);
    cmp(q, 32'(EXTSEL_RST), "mode");
  endtask

  task automatic t_access;
    apb(CFG_OFS, 1, cfg(1, 3'h5, 4'h1, 3'h2, 0, 6'h10));
    apb(CFG_OFS, 0, 0);
    cmp(q, cfg(RUNDIR_RST, LANG_RST, LOCKSEL_RST, STEP_RST, BUZZ_RST,
      6'h10), "guard");
    apb(MODE_OFS, 1, 0);
    for (int l = 0; l < 8; l++) begin
      apb(CFG_OFS, 1, cfg(l[0], l[2:0], 4'h0, 3'h1, 1, 6'h3f));
      // Field lands at the ready edge, the pin follows one edge later
      repeat (2) @(posedge sys_clk);
      cmp(keypadLanguage, l, "lang");
      if (l < 2) begin
        n0 = nRun;
        op.tap(K_RUN, DEB + 3);
        cmp(nRun, n0 + 1, "run");
        cmp(runReverse, l[0], "dir");
      end
    end
    apb(CFG_OFS, 1, cfg(0, 0, 4'h5, 3'h7, 1, 0));
    apb(CFG_OFS, 0, 0);
    cmp(q, cfg(0, 0, 4'h0, 3'h1, 1, 0), "bad codes");
    apb(8'h14, 1, 0);
    cmp(err, 1, "unmapped");
  endtask

  task automatic t_pot;
    for (int c = 0; c < 5; c++) begin
      apb(CFG_OFS, 1, cfg(0, 0, 4'h1, c[2:0], 1, 0));
      apb(FREQ_OFS, 1, 0);
      op.tap(K_UP, DEB + 3);
      cmp(runFreq, stepv[c], "up");
      op.tap(K_DOWN, DEB + 3);
      cmp(runFreq, 0, "down");
    end
    apb(CFG_OFS, 1, cfg(0, 0, 4'h1, 3'h1, 1, 0));
    apb(FREQ_OFS, 1, 32'(FREQ_HIRES));
    op.tap(K_UP, DEB + 3);
    cmp(runFreq, FREQ_HIRES + STEP_0P10, "coarse");
    apb(CFG_OFS, 1, cfg(0, 0, 4'h1, 3'h3, 1, 0));
    apb(FREQ_OFS, 1, 0);
    repeat (CLICKS_PER_TURN) op.tap(K_UP, DEB + 3);
    cmp(runFreq, CLICKS_PER_TURN * STEP_1P00, "turn");
    editSetFreq <= 1'b0;
    n0 = nInc;
    op.tap(K_UP, DEB + 3);
    cmp(nInc, n0 + 1, "other");
    n0 = nDec;
    op.tap(K_DOWN, DEB + 3);
    cmp(nDec, n0 + 1, "other down");
    cmp(runFreq, CLICKS_PER_TURN * STEP_1P00, "kept");
    editSetFreq <= 1'b1;
  endtask

  task automatic t_save;
    repeat (SAVE + 20) @(posedge sys_clk);
    n0 = nNv;
    op.tap(K_DOWN, DEB + 3);
    repeat (SAVE - 30) @(posedge sys_clk);
    cmp(nNv, n0, "early");
    repeat (40) @(posedge sys_clk);
    cmp(nNv, n0 + 1, "store");
    apb(STORE_OFS, 0, 0);
    cmp(q, (CLICKS_PER_TURN - 1) * STEP_1P00, "stored");
    cmp(nvData, (CLICKS_PER_TURN - 1) * STEP_1P00, "nv data");
  endtask

  task automatic t_lock;
    apb(CFG_OFS, 1, cfg(0, 0, 4'h0, 3'h3, 1, 0));
    // Set style: dial moves the edit value, set key commits it
    f = runFreq;
    op.tap(K_UP, DEB + 3);
    cmp(runFreq, f, "set wait");
    op.tap(K_SET, DEB + 3);
    cmp(runFreq, f + STEP_1P00, "set commit");
    op.tap(K_MODE, LP);
    cmp(lockInd, 0, "no lock");
    apb(CFG_OFS, 1, cfg(0, 0, 4'ha, 3'h3, 1, 0));
    op.tap(K_MODE, LP);
    cmp(lockInd, 1, "lock");
    f = runFreq;
    op.tap(K_UP, DEB + 3);
    cmp(lockWarn, 1, "warn");
    cmp(runFreq, f, "dial");
    repeat (IDLE + 10) @(posedge sys_clk);
    cmp(lockWarn, 0, "warn off");
    n0 = nStop;
    op.tap(K_STOP, DEB + 3);
    cmp(nStop, n0 + 1, "stop");
    n0 = nRun;
    op.tap(K_RUN, DEB + 3);
    cmp(nRun, n0, "run held");
    op.resume(LP);
    cmp(lockInd, 0, "unlock");
    cmp(nRun, n0 + 1, "restart");
  endtask

  task automatic t_misc;
    apb(CFG_OFS, 1, cfg(0, 0, 4'hb, 3'h0, 1, 6'h2a));
    n0 = nBeep;
    op.tap(K_SET, DEB + 3);
    cmp(nBeep, n0 + 1, "beep");
    apb(CFG_OFS, 1, cfg(0, 0, 4'hb, 3'h0, 0, 6'h2a));
    n0 = nBeep;
    op.tap(K_SET, DEB + 3);
    cmp(nBeep, n0, "quiet");
    cmp(lcdContrast, 6'h2a, "contrast");
    keypadUnitPresent <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp(contrastListed, 1, "listed");
  endtask

  task automatic wrap_up;
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    editSetFreq = 1'b1;
    keypadUnitPresent = 1'b0;
    reset_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_access;
    t_pot;
    t_save;
    t_lock;
    t_misc;
    wrap_up;
  end
endmodule
`default_nettype wire

// file: pkg/opsc_pkg.sv
`default_nettype none
package opsc_pkg;
  // Clock and timing
  localparam longint CLK_HZ = 250_000_000;
  localparam longint HOLD_TIME_MS = 2000; // Mode key long press
  localparam longint IDLE_TIME_MS = 2000; // Locked warning fallback
  localparam longint SAVE_TIME_MS = 10000; // Delayed store of frequency
  localparam longint DEB_TIME_MS = 5; // Key and dial debounce
  localparam int unsigned HOLD_CYC = 32'(CLK_HZ / 1000 * HOLD_TIME_MS);
  localparam int unsigned IDLE_CYC = 32'(CLK_HZ / 1000 * IDLE_TIME_MS);
  localparam int unsigned SAVE_CYC = 32'(CLK_HZ / 1000 * SAVE_TIME_MS);
  localparam int unsigned DEB_CYC = 32'(CLK_HZ / 1000 * DEB_TIME_MS);

  // Register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] FREQ_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] STORE_OFS = 8'h10;

  // CFG field positions
  localparam int RUNDIR_POS = 0;
  localparam int LANG_POS = 1;
  localparam int LOCKSEL_POS = 4;
  localparam int STEP_POS = 8;
  localparam int BUZZ_POS = 12;
  localparam int CONTRAST_POS = 16;
  // MODE field positions
  localparam int EXTSEL_POS = 0;
  localparam int WPROT_POS = 16;
  localparam int MSPEED_POS = 20;
  // STAT field positions
  localparam int ST_LOCK_POS = 0;
  localparam int ST_WARN_POS = 1;
  localparam int ST_PEND_POS = 2;
  localparam int ST_PU_POS = 3;
  localparam int ST_LIST_POS = 4;

  // Reset values
  localparam logic RUNDIR_RST = 1'b0;
  localparam logic [2:0] LANG_RST = 3'h1;
  localparam logic [3:0] LOCKSEL_RST = 4'h0;
  localparam logic [2:0] STEP_RST = 3'h0;
  localparam logic BUZZ_RST = 1'b1;
  localparam logic [5:0] CONTRAST_RST = 6'h3a;
  localparam logic [15:0] EXTSEL_RST = 16'h270f;
  localparam logic [1:0] WPROT_RST = 2'h0;
  localparam logic MSPEED_RST = 1'b0;

  // Panel operation selection values
  localparam logic [3:0] LOCK_SET_NOLOCK = 4'h0;
  localparam logic [3:0] LOCK_POT_NOLOCK = 4'h1;
  localparam logic [3:0] LOCK_SET_LOCK = 4'ha;
  localparam logic [3:0] LOCK_POT_LOCK = 4'hb;

  // Frequency in 0.01 Hz units
  localparam int FREQ_W = 20;
  localparam logic [19:0] FREQ_RST = 20'h00000;
  localparam logic [19:0] FREQ_MAX = 20'h09c40;
  localparam logic [19:0] FREQ_HIRES = 20'h02710; // 100.00
  localparam logic [19:0] SPEED_HIRES = 20'h186a0; // 1000.00
  localparam logic [19:0] STEP_0P01 = 20'h00001;
  localparam logic [19:0] STEP_0P10 = 20'h0000a;
  localparam logic [19:0] STEP_1P00 = 20'h00064;
  localparam logic [19:0] STEP_10P0 = 20'h003e8;
  localparam logic [2:0] STEP_CODE_MAX = 3'h4;
  localparam int CLICKS_PER_TURN = 24;

  // Debounced input index
  localparam int KEY_N = 6;
  localparam int K_MODE = 0;
  localparam int K_SET = 1;
  localparam int K_RUN = 2;
  localparam int K_STOP = 3;
  localparam int K_UP = 4;
  localparam int K_DOWN = 5;
endpackage
`default_nettype wire
